//--- src/tcc_pkg.sv
// shared constants and types of the timer capture/compare block
package tcc_pkg;
  // machine cycle states, one clock each
  typedef enum logic [2:0] {ST_S1, ST_S2, ST_S3, ST_S4, ST_S5, ST_S6} tcc_state_t;
  // special function register addresses
  localparam logic [7:0] ADDR_CAP_EDGE = 8'hEB;
  localparam logic [7:0] ADDR_CAP_BASE = 8'hA8;
  localparam logic [7:0] ADDR_CMP_BASE = 8'hC8;
  localparam logic [7:0] ADDR_SET_EN = 8'hEE;
  localparam logic [7:0] ADDR_RT_EN = 8'hEF;
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'hE8;
  localparam logic [7:0] ADDR_TIMER_CTL = 8'hEA;
  localparam logic [7:0] ADDR_IRQ_PRIO = 8'hF8;
  localparam logic [7:0] ADDR_PORT4 = 8'hC0;
  // reset values
  localparam logic [7:0] RST_CAP_EDGE = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [1:0] RST_TOG_NEXT = 2'h3;
  // flag positions in the internal flag vector
  localparam int FLG_CAP0 = 0;
  localparam int FLG_CMP_SET = 4;
  localparam int FLG_CMP_RST = 5;
  localparam int FLG_CMP_TOG = 6;
  localparam int FLG_WIDE_OVF = 7;
  localparam int FLG_BYTE_OVF = 8;
  localparam int TCTL_BYTE_OVF_BIT = 4;
  localparam int NUM_FLAGS = 9;
endpackage : tcc_pkg

//--- src/tcc_cap_if.sv
// signals between the main block and its capture unit
`timescale 1ns/10ps
interface tcc_cap_if;
  logic [7:0] cap_cfg;
  logic [15:0] timer;
  logic smp_stb;
  logic load_stb;
  logic [3:0] hit;
  logic [3:0][15:0] value;
  modport ctl (output cap_cfg, output timer, output smp_stb, output load_stb,
               input hit, input value);
  modport unit (input cap_cfg, input timer, input smp_stb, input load_stb,
                output hit, output value);
endinterface : tcc_cap_if

//--- src/tcc_capture.sv
// four capture channels: pin sync, edge select, capture registers
`timescale 1ns/10ps
module tcc_capture (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // capture pins
  input wire logic capture_input_zero,
  input wire logic capture_input_one,
  input wire logic capture_input_two,
  input wire logic capture_input_three,
  // link to main block
  tcc_cap_if.unit bus
);
  logic [3:0] pins;
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] smp;

  assign pins = {capture_input_three, capture_input_two, capture_input_one,
                 capture_input_zero};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_ch
      // bit 2i+1 falling, bit 2i rising; both set gives either edge
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          smp[i] <= 1'b0;
          bus.hit[i] <= 1'b0;
        end else if (bus.smp_stb) begin
          smp[i] <= sync2[i];
          bus.hit[i] <= (bus.cap_cfg[2*i] & sync2[i] & ~smp[i]) |
                        (bus.cap_cfg[2*i+1] & ~sync2[i] & smp[i]);
        end
      end

      // timer value taken at the end of the cycle of the edge
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          bus.value[i] <= tcc_pkg::RST_WORD;
        end else if (bus.load_stb && bus.hit[i]) begin
          bus.value[i] <= bus.timer;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  AST_CAP_RISE: assert property (@(posedge clk) disable iff (!nrst)
    (bus.smp_stb && bus.cap_cfg[0] && sync2[0] && !smp[0]) |=> bus.hit[0])
    else $error("rising edge on channel 0 not caught");
  AST_CAP_FALL3: assert property (@(posedge clk) disable iff (!nrst)
    (bus.smp_stb && bus.cap_cfg[7] && !sync2[3] && smp[3]) |=> bus.hit[3])
    else $error("falling edge on channel 3 not caught");
  AST_CAP_OFF: assert property (@(posedge clk) disable iff (!nrst)
    (bus.smp_stb && bus.cap_cfg[3:2] == 2'h0) |=> !bus.hit[1])
    else $error("disabled channel 1 captured");
  AST_CAP_LOAD: assert property (@(posedge clk) disable iff (!nrst)
    (bus.load_stb && bus.hit[2]) |=> bus.value[2] == $past(bus.timer))
    else $error("capture register 2 not loaded");
  COV_CAP_LOAD: cover property (@(posedge clk) disable iff (!nrst)
    bus.load_stb && bus.hit[0]);
endmodule : tcc_capture

//--- src/tcc_capcomp.sv
// timer capture/compare unit: registers, compare, port 4 and flags
// Functional notes
// - channel 3: bit 7 falling, bit 6 rising
// - channel 2: bit 5 falling, bit 4 rising
// - channel 1: bit 3 falling, bit 2 rising
// - channel 0: bit 1 falling, bit 0 rising
// - reset match clears enabled port bits 0-5
// - toggle match applies inverse of last operation
// - alternation follows only last-operation flip-flops
// - first toggle after reset sets latch
// - last-operation flops read at set-enable bits 6,7
// - compare registers cleared by reset
// - hardware change at S5, software at S1
// - hardware beats software on same bit
// - set and reset together gives reset
// - capture flags 0,1 at S4; 2,3 at S6
// - interrupt scan states per capture flag
// - flag reads happen in S5
// - compare flags set S6 of next cycle
// - overflow flags set S6 of overflow cycle
// - eight flags in register, byte overflow elsewhere
// - priority bit high means high priority
// - set match sets enabled port bits 0-5
// - inputs sampled S1, captured at cycle end
// - compare on every timer increment
`timescale 1ns/10ps
module tcc_capcomp (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // timer
  input wire logic [15:0] timer_value,
  input wire logic timer_inc,
  input wire logic byte_ovf,
  input wire logic wide_ovf,
  // capture pins
  input wire logic capture_input_zero,
  input wire logic capture_input_one,
  input wire logic capture_input_two,
  input wire logic capture_input_three,
  // port 4 and interrupts
  output logic [7:0] port4_out,
  output logic [8:0] irq_req,
  output logic [7:0] irq_high
);
  tcc_pkg::tcc_state_t st;
  logic [7:0] capture_edge_select;
  logic [2:0][15:0] cmp;
  logic [5:0] set_enable;
  logic [7:0] reset_toggle_enable;
  logic [1:0] tog_next;
  logic [8:0] flags;
  logic [2:0] hit;
  logic [2:0] due;
  logic ovf_wide_seen;
  logic ovf_byte_seen;
  logic sw_pend;
  logic [7:0] sw_val;
  logic [7:0] sw_mask;
  logic [2:0] eq;
  logic [5:0] set_m;
  logic [5:0] rst_m;
  logic [1:0] tog_m;
  logic [7:0] hw_mask;
  logic [7:0] next_port;
  logic [8:0] scan;
  logic [8:0] flag_set;
  logic [7:0] next_rdata;

  tcc_cap_if cif ();

  ////////////////////////////////////////////////////////////////////////////////
  // machine cycle sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= tcc_pkg::ST_S1;
    end else begin
      unique case (st)
        tcc_pkg::ST_S1: st <= tcc_pkg::ST_S2;
        tcc_pkg::ST_S2: st <= tcc_pkg::ST_S3;
        tcc_pkg::ST_S3: st <= tcc_pkg::ST_S4;
        tcc_pkg::ST_S4: st <= tcc_pkg::ST_S5;
        tcc_pkg::ST_S5: st <= tcc_pkg::ST_S6;
        tcc_pkg::ST_S6: st <= tcc_pkg::ST_S1;
        default: st <= tcc_pkg::ST_S1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // capture channels
  assign cif.cap_cfg = capture_edge_select;
  assign cif.timer = timer_value;
  assign cif.smp_stb = (st == tcc_pkg::ST_S1);
  assign cif.load_stb = (st == tcc_pkg::ST_S6);

  tcc_capture u_capture (
    .clk(clk),
    .nrst(nrst),
    .capture_input_zero(capture_input_zero),
    .capture_input_one(capture_input_one),
    .capture_input_two(capture_input_two),
    .capture_input_three(capture_input_three),
    .bus(cif.unit)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      capture_edge_select <= tcc_pkg::RST_CAP_EDGE;
      set_enable <= tcc_pkg::RST_BYTE[5:0];
      reset_toggle_enable <= tcc_pkg::RST_BYTE;
      irq_high <= tcc_pkg::RST_BYTE;
    end else if (sfr_wr) begin
      if (sfr_addr == tcc_pkg::ADDR_CAP_EDGE) capture_edge_select <= sfr_wdata;
      if (sfr_addr == tcc_pkg::ADDR_SET_EN) set_enable <= sfr_wdata[5:0];
      if (sfr_addr == tcc_pkg::ADDR_RT_EN) reset_toggle_enable <= sfr_wdata;
      if (sfr_addr == tcc_pkg::ADDR_IRQ_PRIO) irq_high <= sfr_wdata;
    end
  end

  genvar k;
  generate
    for (k = 0; k < 3; k++) begin : g_cmp
      localparam logic [7:0] ALO = tcc_pkg::ADDR_CMP_BASE + 8'(2 * k);
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          cmp[k] <= tcc_pkg::RST_WORD;
        end else if (sfr_wr && sfr_addr == ALO) begin
          cmp[k][7:0] <= sfr_wdata;
        end else if (sfr_wr && sfr_addr == ALO + 8'h01) begin
          cmp[k][15:8] <= sfr_wdata;
        end
      end
      // the timer value presented with the increment is the new count
      assign eq[k] = timer_inc && (timer_value == cmp[k]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // match pipeline: match cycle, then action in the following cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hit <= 3'h0;
      due <= 3'h0;
    end else if (st == tcc_pkg::ST_S6) begin
      due <= hit | eq;
      hit <= 3'h0;
    end else begin
      hit <= hit | eq;
    end
  end

  assign set_m = due[0] ? set_enable : 6'h00;
  assign rst_m = due[1] ? reset_toggle_enable[5:0] : 6'h00;
  assign tog_m = due[2] ? reset_toggle_enable[7:6] : 2'h0;
  assign hw_mask = {tog_m, set_m | rst_m};

  always_comb begin
    next_port = port4_out;
    next_port[5:0] = (port4_out[5:0] | set_m) & ~rst_m;
    for (int j = 0; j < 2; j++) begin
      if (tog_m[j]) next_port[6 + j] = tog_next[j];
    end
  end

  // last-operation flops; the port latch itself is never consulted
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tog_next <= tcc_pkg::RST_TOG_NEXT;
    end else if (st == tcc_pkg::ST_S5) begin
      tog_next <= tog_next ^ tog_m;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // port 4 latch
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sw_pend <= 1'b0;
      sw_val <= tcc_pkg::RST_BYTE;
      sw_mask <= tcc_pkg::RST_BYTE;
      port4_out <= tcc_pkg::RST_BYTE;
    end else begin
      if (st == tcc_pkg::ST_S5) begin
        port4_out <= next_port;
      end else if (st == tcc_pkg::ST_S1 && sw_pend) begin
        port4_out <= (port4_out & sw_mask) | (sw_val & ~sw_mask);
      end
      if (sfr_wr && sfr_addr == tcc_pkg::ADDR_PORT4) begin
        sw_pend <= 1'b1;
        sw_val <= sfr_wdata;
        sw_mask <= (st == tcc_pkg::ST_S5) ? hw_mask : 8'h00;
      end else if (st == tcc_pkg::ST_S1) begin
        sw_pend <= 1'b0;
      end else if (st == tcc_pkg::ST_S5 && sw_pend) begin
        sw_mask <= sw_mask | hw_mask;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt flags
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ovf_wide_seen <= 1'b0;
      ovf_byte_seen <= 1'b0;
    end else if (st == tcc_pkg::ST_S6) begin
      ovf_wide_seen <= 1'b0;
      ovf_byte_seen <= 1'b0;
    end else begin
      ovf_wide_seen <= ovf_wide_seen | wide_ovf;
      ovf_byte_seen <= ovf_byte_seen | byte_ovf;
    end
  end

  always_comb begin
    flag_set = 9'h000;
    if (st == tcc_pkg::ST_S4) flag_set[1:0] = cif.hit[1:0];
    if (st == tcc_pkg::ST_S6) begin
      flag_set[3:2] = cif.hit[3:2];
      flag_set[6:4] = due;
      flag_set[tcc_pkg::FLG_WIDE_OVF] = ovf_wide_seen | wide_ovf;
      flag_set[tcc_pkg::FLG_BYTE_OVF] = ovf_byte_seen | byte_ovf | ovf_wide_seen | wide_ovf;
    end
  end

  // a hardware set in the clearing cycle survives the write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flags <= 9'h000;
    end else begin
      if (sfr_wr && sfr_addr == tcc_pkg::ADDR_IRQ_FLAGS) begin
        flags[7:0] <= sfr_wdata | flag_set[7:0];
      end else begin
        flags[7:0] <= flags[7:0] | flag_set[7:0];
      end
      if (sfr_wr && sfr_addr == tcc_pkg::ADDR_TIMER_CTL) begin
        flags[8] <= sfr_wdata[tcc_pkg::TCTL_BYTE_OVF_BIT] | flag_set[8];
      end else begin
        flags[8] <= flags[8] | flag_set[8];
      end
    end
  end

  // interrupt scan: each request follows its flag only in its scan states (S4 and S5 for flags 2,3; S3 and S4 for flag 6)
  always_comb begin
    scan = 9'h000;
    unique case (st)
      tcc_pkg::ST_S2: scan = 9'h191;
      tcc_pkg::ST_S3: scan = 9'h062;
      tcc_pkg::ST_S4: scan = 9'h04C;
      tcc_pkg::ST_S5: scan = 9'h00C;
      default: scan = 9'h000;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_req <= 9'h000;
    end else begin
      irq_req <= (flags & scan) | (irq_req & ~scan);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register read; the core reads in S5, so polled flags lag accordingly
  always_comb begin
    next_rdata = 8'h00;
    if (sfr_addr[7:3] == tcc_pkg::ADDR_CAP_BASE[7:3]) begin
      next_rdata = sfr_addr[0] ? cif.value[sfr_addr[2:1]][15:8] : cif.value[sfr_addr[2:1]][7:0];
    end
    for (int m = 0; m < 3; m++) begin
      if (sfr_addr == tcc_pkg::ADDR_CMP_BASE + 8'(2 * m)) next_rdata = cmp[m][7:0];
      if (sfr_addr == tcc_pkg::ADDR_CMP_BASE + 8'(2 * m + 1)) next_rdata = cmp[m][15:8];
    end
    if (sfr_addr == tcc_pkg::ADDR_CAP_EDGE) next_rdata = capture_edge_select;
    if (sfr_addr == tcc_pkg::ADDR_SET_EN) next_rdata = {tog_next, set_enable};
    if (sfr_addr == tcc_pkg::ADDR_RT_EN) next_rdata = reset_toggle_enable;
    if (sfr_addr == tcc_pkg::ADDR_IRQ_FLAGS) next_rdata = flags[7:0];
    if (sfr_addr == tcc_pkg::ADDR_TIMER_CTL) next_rdata = {3'h0, flags[8], 4'h0};
    if (sfr_addr == tcc_pkg::ADDR_IRQ_PRIO) next_rdata = irq_high;
    if (sfr_addr == tcc_pkg::ADDR_PORT4) next_rdata = port4_out;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  AST_TOGGLE: assert property (@(posedge clk) disable iff (!nrst)
    (st == tcc_pkg::ST_S5 && due[2] && reset_toggle_enable[6])
    |=> (port4_out[6] == $past(tog_next[0])) && (tog_next[0] != $past(tog_next[0])))
    else $error("toggle did not follow last operation");
  AST_RESET_WINS: assert property (@(posedge clk) disable iff (!nrst)
    (st == tcc_pkg::ST_S5 && due[1:0] == 2'h3 && set_enable[0] && reset_toggle_enable[0])
    |=> !port4_out[0])
    else $error("set beat reset on port bit 0");
  AST_SET_MATCH: assert property (@(posedge clk) disable iff (!nrst)
    (st == tcc_pkg::ST_S5 && due[0] && set_enable[2] && !(due[1] && reset_toggle_enable[2]))
    |=> port4_out[2])
    else $error("set match missed port bit 2");
  AST_RESET_MATCH: assert property (@(posedge clk) disable iff (!nrst)
    (st == tcc_pkg::ST_S5 && due[1] && reset_toggle_enable[1]) |=> !port4_out[1])
    else $error("reset match missed port bit 1");
  AST_HW_WINS: assert property (@(posedge clk) disable iff (!nrst)
    (st == tcc_pkg::ST_S5 && due[1] && reset_toggle_enable[3] && sfr_wr
     && sfr_addr == tcc_pkg::ADDR_PORT4 && sfr_wdata[3] && !due[0])
    |=> (!port4_out[3]) [*5])
    else $error("software write overrode compare result");
  AST_SW_AT_S1: assert property (@(posedge clk) disable iff (!nrst)
    (st == tcc_pkg::ST_S6 && sfr_wr && sfr_addr == tcc_pkg::ADDR_PORT4)
    |-> ##2 port4_out == $past(sfr_wdata, 2))
    else $error("software port write not applied at S1");
  AST_FIRST_TOGGLE: assert property (@(posedge clk) disable iff (!nrst)
    $rose(nrst) |-> tog_next == 2'h3 && cmp[0] == 16'h0000 && cmp[2] == 16'h0000)
    else $error("reset state of toggle or compare wrong");
  AST_CAP_FLAG01: assert property (@(posedge clk) disable iff (!nrst)
    (st == tcc_pkg::ST_S4 && cif.hit[1]) |=> flags[1])
    else $error("capture flag 1 not set in S4");
  AST_CAP_FLAG23: assert property (@(posedge clk) disable iff (!nrst)
    (st != tcc_pkg::ST_S6) |=> !$rose(flags[2]))
    else $error("capture flag 2 set outside S6");
  AST_CMP_FLAG: assert property (@(posedge clk) disable iff (!nrst)
    eq[1] |-> ##[7:12] flags[tcc_pkg::FLG_CMP_RST])
    else $error("compare flag late");
  AST_OVF_FLAG: assert property (@(posedge clk) disable iff (!nrst)
    wide_ovf |-> ##[1:6] (flags[tcc_pkg::FLG_WIDE_OVF] && flags[tcc_pkg::FLG_BYTE_OVF]))
    else $error("overflow flags not set");
  AST_SCAN0: assert property (@(posedge clk) disable iff (!nrst)
    (st == tcc_pkg::ST_S2) |=> irq_req[0] == $past(flags[0]))
    else $error("flag 0 not scanned in S2");
  AST_STE_READ: assert property (@(posedge clk) disable iff (!nrst)
    (sfr_rd && sfr_addr == tcc_pkg::ADDR_SET_EN) |=> sfr_rdata[7:6] == $past(tog_next))
    else $error("last operation flops not readable");
  COV_TOGGLE: cover property (@(posedge clk) disable iff (!nrst)
    st == tcc_pkg::ST_S5 && tog_m[1]);
  COV_CONFLICT: cover property (@(posedge clk) disable iff (!nrst)
    st == tcc_pkg::ST_S5 && (set_m & rst_m) != 6'h00);
  COV_HW_SW: cover property (@(posedge clk) disable iff (!nrst)
    st == tcc_pkg::ST_S5 && sfr_wr && sfr_addr == tcc_pkg::ADDR_PORT4 && hw_mask != 8'h00);
endmodule : tcc_capcomp

//--- tb/tcc_pins.sv
// external pin model: capture event sources for the four channels
`timescale 1ns/10ps
module tcc_pins (
  // clock
  input wire logic clk,
  // commanded levels
  input wire logic [3:0] lvl,
  // capture pins
  output logic [3:0] cap_pin
);
  initial cap_pin = 4'h0;
  // change just after an edge, so each S1 sample sees one settled level
  always @(posedge clk) begin
    cap_pin <= lvl;
  end
endmodule : tcc_pins

//--- tb/testbench.sv
// self-checking bench for the capture/compare block
`timescale 1ns/10ps
module testbench;
  logic clk, nrst, sfr_wr, sfr_rd, timer_inc, byte_ovf, wide_ovf;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, port4_out, irq_high;
  logic [15:0] timer_value, tv;
  logic [8:0] irq_req;
  logic [3:0] lvl, cap_pin;
  logic [2:0] ph;
  int n_fail, n_tests;

  tcc_capcomp u_tcc_capcomp (.clk(clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .timer_value(timer_value),
    .timer_inc(timer_inc), .byte_ovf(byte_ovf), .wide_ovf(wide_ovf),
    .capture_input_zero(cap_pin[0]), .capture_input_one(cap_pin[1]),
    .capture_input_two(cap_pin[2]), .capture_input_three(cap_pin[3]),
    .port4_out(port4_out), .irq_req(irq_req), .irq_high(irq_high));
  tcc_pins u_tcc_pins (.clk(clk), .lvl(lvl), .cap_pin(cap_pin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // machine phase per the bus contract: S1 on the first edge after reset release
  always @(posedge clk) begin
    ph <= (!nrst || ph == 3'h5) ? 3'h0 : ph + 3'h1;
  end

  ////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask : wr

  // read data is registered at the strobe edge, looked at half a cycle on
  task rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    @(negedge clk);
    chk(nm, sfr_rdata, e);
  endtask : rd

  // one timer increment hitting v; port must not move before the next cycle's S5
  task hw(input logic [15:0] v, input logic [7:0] old, input logic [7:0] e,
          input logic [7:0] fl);
    @(posedge clk);
    timer_value <= v;
    timer_inc <= 1'b1;
    @(posedge clk);
    timer_inc <= 1'b0;
    cyc(3);
    @(negedge clk);
    chk("port4_early", port4_out, old);
    // latest possible action is the S5 edge ten clocks after the match edge
    cyc(12);
    @(negedge clk);
    chk("port4", port4_out, e);
    cyc(8);
    rd(tcc_pkg::ADDR_IRQ_FLAGS, fl, "cmp_flags");
    wr(tcc_pkg::ADDR_IRQ_FLAGS, 8'h00);
  endtask : hw

  task close_out;
    if (n_fail == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_fail++;
    close_out();
  end

  initial begin
    n_fail = 0;
    n_tests = 0;
    nrst = 1'b0;
    {sfr_wr, sfr_rd, timer_inc, byte_ovf, wide_ovf} = 5'h00;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    timer_value = 16'h0000;
    lvl = 4'h0;
    cyc(5);
    nrst <= 1'b1;
    rd(tcc_pkg::ADDR_CAP_EDGE, 8'h00, "edge_sel_rst");
    rd(tcc_pkg::ADDR_SET_EN, 8'hC0, "set_en_rst");
    rd(tcc_pkg::ADDR_CMP_BASE, 8'h00, "cmp_rst");
    rd(8'h00, 8'h00, "unmapped");
    // every single edge-select bit, one channel at a time
    for (int i = 0; i < 4; i++) begin
      for (int e = 0; e < 2; e++) begin
        tv = 16'h1200 + 16'(i * 2 + e);
        wr(tcc_pkg::ADDR_CAP_EDGE, 8'h01 << (2 * i + e));
        @(posedge clk);
        timer_value <= tv;
        lvl[i] <= (e == 0);
        cyc(24);
        rd(tcc_pkg::ADDR_IRQ_FLAGS, 8'h01 << i, "cap_flag");
        rd(tcc_pkg::ADDR_CAP_BASE + 8'(2 * i), tv[7:0], "cap_lo");
        rd(tcc_pkg::ADDR_CAP_BASE + 8'(2 * i + 1), tv[15:8], "cap_hi");
        chk("irq_cap", 16'(irq_req[i]), 16'h0001);
        wr(tcc_pkg::ADDR_IRQ_FLAGS, 8'h00);
      end
    end
    // disabled channels stay silent, both bits set catch a falling edge
    wr(tcc_pkg::ADDR_CAP_EDGE, 8'h00);
    lvl <= 4'hF;
    cyc(24);
    rd(tcc_pkg::ADDR_IRQ_FLAGS, 8'h00, "cap_none");
    wr(tcc_pkg::ADDR_CAP_EDGE, 8'hFF);
    lvl <= 4'h0;
    cyc(24);
    rd(tcc_pkg::ADDR_IRQ_FLAGS, 8'h0F, "cap_either");
    wr(tcc_pkg::ADDR_IRQ_FLAGS, 8'h00);
    // compare: set, partial reset, toggles
    wr(tcc_pkg::ADDR_SET_EN, 8'h3F);
    wr(tcc_pkg::ADDR_RT_EN, 8'hC5);
    wr(tcc_pkg::ADDR_CMP_BASE, 8'h10);
    wr(tcc_pkg::ADDR_CMP_BASE + 8'h02, 8'h20);
    wr(tcc_pkg::ADDR_CMP_BASE + 8'h04, 8'h30);
    hw(16'h0010, 8'h00, 8'h3F, 8'h10);
    hw(16'h0020, 8'h3F, 8'h3A, 8'h20);
    hw(16'h0030, 8'h3A, 8'hFA, 8'h40);
    rd(tcc_pkg::ADDR_SET_EN, 8'h3F, "tog_next_low");
    wr(tcc_pkg::ADDR_PORT4, 8'h00);
    cyc(8);
    chk("port4_sw", port4_out, 8'h00);
    hw(16'h0030, 8'h00, 8'h00, 8'h40);
    rd(tcc_pkg::ADDR_SET_EN, 8'hFF, "tog_next_high");
    // set and reset matching together
    wr(tcc_pkg::ADDR_RT_EN, 8'hFF);
    wr(tcc_pkg::ADDR_CMP_BASE + 8'h02, 8'h10);
    hw(16'h0010, 8'h00, 8'h00, 8'h30);
    // software write sampled on the very S5 edge of a reset match
    wr(tcc_pkg::ADDR_CMP_BASE + 8'h02, 8'h20);
    @(posedge clk);
    while (ph != 3'h5) @(posedge clk);
    timer_value <= 16'h0020;
    timer_inc <= 1'b1;
    @(posedge clk);
    timer_inc <= 1'b0;
    cyc(8);
    wr(tcc_pkg::ADDR_PORT4, 8'hFF);
    cyc(3);
    @(negedge clk);
    chk("port4_hw_wins", port4_out, 8'hC0);
    rd(tcc_pkg::ADDR_IRQ_FLAGS, 8'h20, "hw_wins_flag");
    wr(tcc_pkg::ADDR_IRQ_FLAGS, 8'h00);
    // overflow flags, byte one lives in the control register
    @(posedge clk);
    byte_ovf <= 1'b1;
    @(posedge clk);
    byte_ovf <= 1'b0;
    cyc(8);
    rd(tcc_pkg::ADDR_TIMER_CTL, 8'h10, "byte_ovf_flag");
    rd(tcc_pkg::ADDR_IRQ_FLAGS, 8'h00, "byte_only");
    wr(tcc_pkg::ADDR_TIMER_CTL, 8'h00);
    @(posedge clk);
    wide_ovf <= 1'b1;
    @(posedge clk);
    wide_ovf <= 1'b0;
    cyc(8);
    rd(tcc_pkg::ADDR_IRQ_FLAGS, 8'h80, "wide_ovf_flag");
    rd(tcc_pkg::ADDR_TIMER_CTL, 8'h10, "wide_sets_byte");
    cyc(6);
    chk("irq_ovf", 16'(irq_req[8:7]), 16'h0003);
    // priority register straight to the outputs
    wr(tcc_pkg::ADDR_IRQ_PRIO, 8'hA5);
    cyc(1);
    @(negedge clk);
    chk("irq_high", irq_high, 8'hA5);
    rd(tcc_pkg::ADDR_IRQ_PRIO, 8'hA5, "prio_rd");
    close_out();
  end
endmodule : testbench
